// ### hdl/irq_unit.v
// six-source vectored interrupt unit with programmable priority
//
// Function
// RQ1 - six maskable prioritized requests, four external, two timer
// RQ2 - falling edges on three inputs, rising on input two
// RQ3 - request n uses vector bytes 2n and 2n+1
// RQ4 - per-request mask plus one global enable
// RQ5 - priority register orders pending requests
// RQ6 - grant disables interrupts; core saves and branches
// RQ7 - vector byte pair forms 16-bit service address
// RQ8 - masked requests still visible for polling
// RQ9 - comparator mode: comp2 both edges, comp1 falling
// RQ10 - pending stays set until grant or clear
//
// ---------------------------------------------
// notes for integrators
// ---------------------------------------------
// - pins idle high and the edge detectors reset to that level,
//   so a pin held low through reset yields one falling request
// - timer inputs are single-cycle events; a level held high keeps
//   re-setting its pending bit every cycle
// - every grant drops the global enable; software rewrites the
//   mask to re-arm, which keeps nested service out of hardware
// - priority codes 6 and 7 both give the fixed order 5 first
//   down to 0; codes 0 to 5 rotate with that id on top
// - polled use: leave the global enable low and read pending_q
// - the core must hold the vector bytes while take_irq is high
`timescale 1ns/1ps
`include "irq_unit_defines.vh"
module irq_unit #(
    parameter NUM_REQ = `NUM_REQ
) (
    input wire ref_clk,
    input wire nrst,
    input wire analog_input_one,
    input wire analog_input_two,
    input wire port3_line3,
    input wire comparator_mode,
    input wire comparator_one_out,
    input wire comparator_two_out,
    input wire counter_timer_zero,
    input wire counter_timer_one,
    input wire [6:0] mask_wdata,
    input wire mask_we,
    input wire [2:0] prio_wdata,
    input wire prio_we,
    input wire [5:0] pend_clear,
    input wire [5:0] pend_set,
    input wire take_irq,
    input wire [7:0] vec_byte_lo,
    input wire [7:0] vec_byte_hi,
    output reg [5:0] pending_q,
    output reg [6:0] mask_q,
    output reg [2:0] prio_q,
    output reg irq_req_q,
    output reg [2:0] grant_id_q,
    output reg [3:0] vec_addr_q,
    output reg grant_q,
    output reg [15:0] isr_addr_q
);

// ---------------------------------------------
// edge detection
// ---------------------------------------------
// previous-cycle copies of each pin
reg a1_q;
reg a2_q;
reg ref_q;
reg c1_q;
reg c2_q;
wire src_fall_a;
wire src_fall_b;
wire src_rise_b;
// bit order of edge_ev follows the request numbers
wire [5:0] edge_ev;
wire comp2_any;

// RQ9 comparator edge source
assign comp2_any = c2_q ^ comparator_two_out;
// comparator mode replaces the two analog falling sources with the comparator ones and turns the
// rising source off, so no request number is shared twice
// RQ2 edge selection per source
assign src_fall_a = comparator_mode ? (c1_q & ~comparator_one_out)
                                    : (a1_q & ~analog_input_one);
assign src_fall_b = comparator_mode ? comp2_any : (a2_q & ~analog_input_two);
assign src_rise_b = comparator_mode ? 1'b0 : (~a2_q & analog_input_two);
// RQ1 six request sources; RQ2 rising edge on request three
assign edge_ev = {counter_timer_one, counter_timer_zero, src_rise_b,
                  src_fall_a, (ref_q & ~port3_line3), src_fall_b};

always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        a1_q <= `EDGE_IDLE;
        a2_q <= `EDGE_IDLE;
        ref_q <= `EDGE_IDLE;
        c1_q <= `EDGE_IDLE;
        c2_q <= `EDGE_IDLE;
    end else begin
        a1_q <= analog_input_one;
        a2_q <= analog_input_two;
        ref_q <= port3_line3;
        c1_q <= comparator_one_out;
        c2_q <= comparator_two_out;
    end
end

// ---------------------------------------------
// pending, mask and priority state
// ---------------------------------------------
reg [5:0] grant_clr;
wire [5:0] pend_d;
wire grant_fire;

// one grant per request; the grant cycle itself is blocked so a
// lingering take_irq cannot fire twice
assign grant_fire = take_irq & irq_req_q & ~grant_q;

// only the granted id is cleared
always @* begin
    grant_clr = `PEND_RESET;
    if (grant_fire) begin
        grant_clr[grant_id_q] = 1'b1;
    end
end

// RQ10 set wins over clear; RQ8 records regardless of mask
genvar g;
generate
    for (g = 0; g < NUM_REQ; g = g + 1) begin : pend_bit
        // a clear in the event cycle loses, so no event is dropped
        assign pend_d[g] = edge_ev[g] | pend_set[g] |
                           (pending_q[g] & ~(pend_clear[g] | grant_clr[g]));
    end
endgenerate

always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        pending_q <= `PEND_RESET;
        mask_q <= `MASK_RESET;
        prio_q <= `PRIO_RESET;
    end else begin
        pending_q <= pend_d;
        // RQ6 grant clears global enable
        if (grant_fire) begin
            mask_q <= {1'b0, mask_q[5:0]};
        end else if (mask_we) begin
            mask_q <= mask_wdata;
        end
        if (prio_we) begin
            prio_q <= prio_wdata;
        end
    end
end

// ---------------------------------------------
// priority encoder
// ---------------------------------------------
wire [5:0] active;
reg [17:0] order;
reg [2:0] win_d;
reg any_d;
integer j;

// RQ4 individual and global gating
assign active = pending_q & mask_q[5:0] & {6{mask_q[`MASK_GLOBAL_BIT]}};

// rank 0 sits in the low field of order; a table costs less
// than a barrel rotate and keeps the two spare codes defined
// RQ5 priority register selects the search order
always @* begin
    case (prio_q)
        3'h0: order = `ORDER_P0;
        3'h1: order = `ORDER_P1;
        3'h2: order = `ORDER_P2;
        3'h3: order = `ORDER_P3;
        3'h4: order = `ORDER_P4;
        3'h5: order = `ORDER_P5;
        default: order = `ORDER_FIXED;
    endcase
    win_d = `ID_RESET;
    any_d = 1'b0;
    // last hit in the loop is the first in order: scan from rank 5 down to rank 0
    for (j = NUM_REQ - 1; j >= 0; j = j - 1) begin
        if (active[order[3*j +: 3]]) begin
            win_d = order[3*j +: 3];
            any_d = 1'b1;
        end
    end
end

// ---------------------------------------------
// grant and vector fetch
// ---------------------------------------------
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        irq_req_q <= 1'b0;
        grant_id_q <= `ID_RESET;
        vec_addr_q <= `VEC_RESET;
        grant_q <= 1'b0;
        isr_addr_q <= `ISR_RESET;
    end else begin
        grant_q <= 1'b0;
        // request frozen once granted so the id stays with the vector
        // id and vector are not updated in the grant cycle, so the
        // core sees them match the bytes that it just served
        if (grant_fire) begin
            irq_req_q <= 1'b0;
            // RQ6 grant pulse to core for save and branch
            grant_q <= 1'b1;
            // RQ7 byte pair read as one 16-bit address
            isr_addr_q <= {vec_byte_lo, vec_byte_hi};
        end else begin
            irq_req_q <= any_d;
            grant_id_q <= win_d;
            // RQ3 vector pair starts at twice the id
            vec_addr_q <= {win_d, 1'b0};
        end
    end
end

endmodule // irq_unit

// ### hdl/irq_unit_defines.vh
// constants for the six-source vectored interrupt unit
`ifndef IRQ_UNIT_DEFINES_VH
`define IRQ_UNIT_DEFINES_VH
`define NUM_REQ 6
`define REQ_ZERO 0
`define REQ_ONE 1
`define REQ_TWO 2
`define REQ_THREE 3
`define REQ_FOUR 4
`define REQ_FIVE 5
`define MASK_RESET 7'h00
`define PRIO_RESET 3'h0
`define PEND_RESET 6'h00
`define PRIO_WIDTH 3
`define VEC_WIDTH 4
`define ADDR_WIDTH 16
`define MASK_GLOBAL_BIT 6
`define EDGE_IDLE 1'b1
`define ID_RESET 3'h0
`define VEC_RESET 4'h0
`define ISR_RESET 16'h0000
`define ORDER_P0 {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}
`define ORDER_P1 {3'h0, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1}
`define ORDER_P2 {3'h1, 3'h0, 3'h5, 3'h4, 3'h3, 3'h2}
`define ORDER_P3 {3'h2, 3'h1, 3'h0, 3'h5, 3'h4, 3'h3}
`define ORDER_P4 {3'h3, 3'h2, 3'h1, 3'h0, 3'h5, 3'h4}
`define ORDER_P5 {3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h5}
`define ORDER_FIXED {3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5}
`endif

// ### verif/irq_unit_assertions.sv
// port checker for the interrupt unit
`timescale 1ns/1ps
module irq_unit_assertions (
    input wire ref_clk, nrst, take_irq, counter_timer_zero, irq_req_q, grant_q,
    input wire [5:0] pend_clear, pending_q,
    input wire [6:0] mask_q,
    input wire [7:0] vec_byte_lo, vec_byte_hi,
    input wire [2:0] grant_id_q,
    input wire [3:0] vec_addr_q,
    input wire [15:0] isr_addr_q
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!nrst);
chk_grant_pulse: assert property (grant_q |=> !grant_q) else $error("long grant");
chk_grant_cause: assert property (grant_q |-> $past(take_irq && irq_req_q))
    else $error("stray grant");
chk_grant_off: assert property (grant_q |-> !mask_q[6] && !irq_req_q)
    else $error("still enabled");
chk_isr_pair: assert property (grant_q |-> isr_addr_q == $past({vec_byte_lo, vec_byte_hi}))
    else $error("bad isr");
chk_vec_pair: assert property (irq_req_q |-> vec_addr_q == {grant_id_q, 1'b0})
    else $error("bad vector");
chk_req_mask: assert property (irq_req_q |-> $past(mask_q[6] && (pending_q & mask_q[5:0]) != 0))
    else $error("masked request");
chk_timer_set: assert property (counter_timer_zero |=> pending_q[4] || grant_q)
    else $error("lost timer");
chk_pend_hold: assert property ($fell(pending_q[1]) |-> $past(pend_clear[1]) || grant_q)
    else $error("lost pending");
cover property (grant_q && grant_id_q == 3'h5);
cover property (irq_req_q && !mask_q[0]);
cover property ($fell(pending_q[1]) && !grant_q);
endmodule // irq_unit_assertions

// ### verif/core_model.sv
// core sequencer model: takes requests, serves vector bytes
`timescale 1ns/1ps
module core_model (
    input wire ref_clk,
    input wire core_en,
    input wire irq_req_q,
    input wire [3:0] vec_addr_q,
    output reg take_irq = 0,
    output reg [7:0] vec_byte_lo = 0,
    output reg [7:0] vec_byte_hi = 0
);
wire t = core_en && irq_req_q;
wire [7:0] lo = {4'ha, vec_addr_q};
wire [7:0] hi = {4'hb, vec_addr_q + 4'h1};
always @(posedge ref_clk) begin
    take_irq <= #1 t;
    // idle bytes inverted so a stale value never matches
    vec_byte_lo <= #1 t ? lo : ~lo;
    vec_byte_hi <= #1 t ? hi : ~hi;
end
endmodule // core_model

// ### verif/tb_irq_unit.sv
// self-checking bench for the interrupt unit
`timescale 1ns/1ps
module tb_irq_unit;
reg ref_clk = 0, nrst = 0, analog_input_one = 1, analog_input_two = 1, port3_line3 = 1;
reg comparator_mode = 0, comparator_one_out = 1, comparator_two_out = 1, core_en = 0;
reg counter_timer_zero = 0, counter_timer_one = 0, mask_we = 0, prio_we = 0;
reg [6:0] mask_wdata = 0;
reg [2:0] prio_wdata = 0;
reg [5:0] pend_clear = 0, pend_set = 0;
wire take_irq, irq_req_q, grant_q;
wire [7:0] vec_byte_lo, vec_byte_hi;
wire [5:0] pending_q;
wire [6:0] mask_q;
wire [2:0] prio_q, grant_id_q;
wire [3:0] vec_addr_q;
wire [15:0] isr_addr_q;
int n_errors = 0, samples_checked = 0, cyc = 0, i, k;
// mask, priority, set, winner
logic [18:0] rows [5] = '{{7'h7f, 3'h0, 6'h3f, 3'h0}, {7'h7f, 3'h3, 6'h3f, 3'h3},
    {7'h7f, 3'h6, 6'h3f, 3'h5}, {7'h7f, 3'h2, 6'h03, 3'h0}, {7'h7e, 3'h0, 6'h3f, 3'h1}};
irq_unit dut_u (.*);
core_model core_u (.*);
always #25 ref_clk = ~ref_clk;
task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
endtask
task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        n_errors++;
        $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
endtask
task end_of_test;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task pend(input logic [5:0] e);
    tick(2);
    check(pending_q, e);
    check(irq_req_q, 16'h0);
    pend_clear = 6'h3f;
    tick(1);
    pend_clear = 0;
endtask
always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
        n_errors++;
        end_of_test();
    end
end
initial begin
    tick(5);
    nrst = 1;
    tick(1);
    check({pending_q, mask_q, irq_req_q, grant_q}, 16'h0);
    analog_input_one = 0;
    pend(6'h04);
    analog_input_two = 0;
    pend(6'h01);
    analog_input_two = 1;
    pend(6'h08);
    port3_line3 = 0;
    pend(6'h02);
    {counter_timer_zero, counter_timer_one} = 2'h3;
    tick(1);
    {counter_timer_zero, counter_timer_one} = 2'h0;
    pend(6'h30);
    comparator_mode = 1;
    comparator_two_out = 0;
    pend(6'h01);
    comparator_two_out = 1;
    pend(6'h01);
    comparator_one_out = 0;
    pend(6'h04);
    comparator_mode = 0;
    for (i = 0; i < 5; i++) begin
        {mask_wdata, prio_wdata, pend_set} = rows[i][18:3];
        {mask_we, prio_we} = 2'h3;
        tick(1);
        {mask_we, prio_we, pend_set} = 8'h0;
        core_en = 1;
        check(prio_q, rows[i][11:9]);
        for (k = 0; k < 20 && grant_q !== 1'b1; k++) tick(1);
        check(grant_id_q, rows[i][2:0]);
        check(isr_addr_q, {4'ha, rows[i][2:0], 1'b0, 4'hb, rows[i][2:0], 1'b1});
        core_en = 0;
        tick(2);
        check({mask_q[6], irq_req_q}, 16'h0);
        pend(pending_q);
    end
    {pend_set, pend_clear} = {6'h20, 6'h3f};
    tick(1);
    {pend_set, pend_clear} = 12'h0;
    check(pending_q, 6'h20);
    pend(6'h20);
    {analog_input_one, port3_line3, comparator_one_out} = 3'h7;
    tick(1);
    nrst = 0;
    tick(2);
    check({pending_q, mask_q, irq_req_q, grant_q}, 16'h0);
    nrst = 1;
    tick(1);
    check({pending_q, mask_q, irq_req_q, grant_q}, 16'h0);
    check(prio_q, 16'h0);
    end_of_test();
end
endmodule // tb_irq_unit
bind irq_unit irq_unit_assertions chk_u (.*);
